// *** src/rgnp_regs.svh ***
// Function
// - base register region field reads current selection
// - attribute register targets the selected region
// - attribute register takes word and halfword writes
// - bit 28 set forbids instruction fetches
// - attribute fields at their fixed bit positions
// - subregion disable bits 15:8, one disables
// - region size is two to size plus one
// - base field is bits 31 down to N
// - 4 GB region uses base zero
// - valid zero keeps selection, updates current base
// - valid one reloads selection, then updates base
// - valid bit always reads as zero
// - eight regions, three bit region field
`ifndef RGNP_REGS_SVH
`define RGNP_REGS_SVH
`define RGNP_OFS_SEL        12'h000
`define RGNP_OFS_BASE       12'h004
`define RGNP_OFS_ATTR       12'h008
`define RGNP_OFS_BASE_A1    12'h00C
`define RGNP_OFS_ATTR_A1    12'h010
`define RGNP_OFS_BASE_A2    12'h014
`define RGNP_OFS_ATTR_A2    12'h018
`define RGNP_NUM_REGIONS    8
`define RGNP_FETCH_DIS_BIT  28
`define RGNP_PERM_HI        26
`define RGNP_PERM_LO        24
`define RGNP_TEXT_HI        21
`define RGNP_TEXT_LO        19
`define RGNP_SHARE_BIT      18
`define RGNP_CACHE_BIT      17
`define RGNP_BUFF_BIT       16
`define RGNP_SRD_HI         15
`define RGNP_SRD_LO         8
`define RGNP_SIZE_HI        5
`define RGNP_SIZE_LO        1
`define RGNP_ENABLE_BIT     0
`define RGNP_VALID_BIT      4
`define RGNP_ATTR_MASK      32'h173FFF3F
`define RGNP_BASE_MASK      32'hFFFFFFE0
`define RGNP_SIZE_FULL      5'h1F
`define RGNP_RESET_WORD     32'h00000000
`endif

// *** src/rgnp_pkg.sv ***
package rgnp_pkg;
    typedef logic [2:0]  rgnp_idx_t;
    typedef logic [31:0] rgnp_word_t;
    typedef enum logic [1:0] {RGNP_NONE, RGNP_SELR, RGNP_BASER, RGNP_ATTRR} rgnp_kind_t;
endpackage

// *** src/rgnp_decode.sv ***
`timescale 1ns/1ps
`include "rgnp_regs.svh"
module rgnp_decode
    import rgnp_pkg::*;
(
    // address in
    input  wire logic [11:0] addr,
    // decoded kind
    output rgnp_kind_t       kind
);
    always_comb begin
        case (addr)
            `RGNP_OFS_SEL:     kind = RGNP_SELR;
            // aliases share the primary decode
            `RGNP_OFS_BASE,
            `RGNP_OFS_BASE_A1,
            `RGNP_OFS_BASE_A2: kind = RGNP_BASER;
            `RGNP_OFS_ATTR,
            `RGNP_OFS_ATTR_A1,
            `RGNP_OFS_ATTR_A2: kind = RGNP_ATTRR;
            default:           kind = RGNP_NONE;
        endcase
    end
endmodule

// *** src/rgnp_base_eff.sv ***
`timescale 1ns/1ps
`include "rgnp_regs.svh"
module rgnp_base_eff
    import rgnp_pkg::*;
(
    // stored fields
    input  wire logic [31:0] base_raw,
    input  wire logic [4:0]  size,
    // effective base
    output rgnp_word_t       base_eff
);
    logic [5:0]  n;
    logic [31:0] mask;
    always_comb begin
        n = {1'b0, size} + 6'h01;
        mask = 32'hFFFFFFFF << n;
        if (size == `RGNP_SIZE_FULL) begin
            base_eff = 32'h00000000;
        end else begin
            base_eff = base_raw & mask;
        end
    end
endmodule

// *** src/rgnp_top.sv ***
`timescale 1ns/1ps
`include "rgnp_regs.svh"
module rgnp_top
    import rgnp_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // per-region view for the checker, region chosen by VIEW_SEL
    input  wire logic [2:0]  VIEW_SEL,
    output logic      [31:0] VIEW_BASE,
    output logic      [31:0] VIEW_ATTR,
    output logic             VIEW_FETCH_DIS,
    output logic      [7:0]  VIEW_SRD,
    output logic             VIEW_ENABLE
);
    logic [31:0] base_mem_r [0:`RGNP_NUM_REGIONS-1];
    logic [31:0] attr_mem_r [0:`RGNP_NUM_REGIONS-1];
    logic [2:0]  sel_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] vbase_r;
    logic [31:0] vattr_r;
    logic        vfd_r;
    logic [7:0]  vsrd_r;
    logic        ven_r;
    rgnp_kind_t  kind;
    logic        acc;
    logic        wr;
    logic [2:0]  tgt;
    logic [31:0] bmask;
    logic [31:0] attr_nxt;
    logic [31:0] rd_nxt;
    logic [31:0] veff;

    rgnp_decode u_dec (
        .addr (PADDR),
        .kind (kind)
    );

    rgnp_base_eff u_eff (
        .base_raw (base_mem_r[VIEW_SEL]),
        .size     (attr_mem_r[VIEW_SEL][`RGNP_SIZE_HI:`RGNP_SIZE_LO]),
        .base_eff (veff)
    );

    // access is taken in the first enable cycle, PREADY follows one cycle later
    assign acc = PSEL && PENABLE && !pready_r;
    assign wr = acc && PWRITE && (kind != RGNP_NONE);
    // valid bit retargets the written region
    assign tgt = PWDATA[`RGNP_VALID_BIT] ? PWDATA[2:0] : sel_r;

    // byte lanes: word or halfword writes
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign bmask[g*8 +: 8] = PSTRB[g] ? 8'hFF : 8'h00;
        end
    endgenerate

    always_comb begin
        attr_nxt = (attr_mem_r[sel_r] & ~bmask) | (PWDATA & bmask);
        attr_nxt = attr_nxt & `RGNP_ATTR_MASK;
    end

    always_comb begin
        case (kind)
            RGNP_SELR:  rd_nxt = {29'h0, sel_r};
            // valid reads zero, region field shows selection
            RGNP_BASER: rd_nxt = (base_mem_r[sel_r] & `RGNP_BASE_MASK)
                                 | {29'h0, sel_r};
            RGNP_ATTRR: rd_nxt = attr_mem_r[sel_r];
            default:    rd_nxt = 32'h00000000;
        endcase
    end

    // region selection
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sel_r <= 3'h0;
        end else if (wr && kind == RGNP_SELR && PSTRB[0]) begin
            sel_r <= PWDATA[2:0];
        end else if (wr && kind == RGNP_BASER && PSTRB[0] && PWDATA[`RGNP_VALID_BIT]) begin
            sel_r <= PWDATA[2:0];
        end
    end

    // per-region storage
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < `RGNP_NUM_REGIONS; i++) begin
                base_mem_r[i] <= `RGNP_RESET_WORD;
                attr_mem_r[i] <= `RGNP_RESET_WORD;
            end
        end else if (wr && kind == RGNP_BASER && PSTRB == 4'hF) begin
            base_mem_r[tgt] <= PWDATA & `RGNP_BASE_MASK;
        end else if (wr && kind == RGNP_ATTRR) begin
            attr_mem_r[sel_r] <= attr_nxt;
        end
    end

    // apb response
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= PSEL && PENABLE && !pready_r;
            pslverr_r <= acc && (kind == RGNP_NONE);
            prdata_r <= (acc && !PWRITE) ? rd_nxt : 32'h00000000;
        end
    end

    // registered region view, attributes passed raw
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            vbase_r <= 32'h00000000;
            vattr_r <= 32'h00000000;
            vfd_r <= 1'b0;
            vsrd_r <= 8'h00;
            ven_r <= 1'b0;
        end else begin
            vbase_r <= veff;
            vattr_r <= attr_mem_r[VIEW_SEL];
            vfd_r <= attr_mem_r[VIEW_SEL][`RGNP_FETCH_DIS_BIT];
            vsrd_r <= attr_mem_r[VIEW_SEL][`RGNP_SRD_HI:`RGNP_SRD_LO];
            ven_r <= attr_mem_r[VIEW_SEL][`RGNP_ENABLE_BIT];
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign VIEW_BASE = vbase_r;
    assign VIEW_ATTR = vattr_r;
    assign VIEW_FETCH_DIS = vfd_r;
    assign VIEW_SRD = vsrd_r;
    assign VIEW_ENABLE = ven_r;

    property p_valid_reads_zero;
        @(posedge CLK) disable iff (SYS_RST)
        (acc && !PWRITE && kind == RGNP_BASER) |=> !PRDATA[`RGNP_VALID_BIT];
    endproperty
    a_valid_reads_zero: assert property (p_valid_reads_zero) else $error("valid bit read one");

    property p_region_reads_sel;
        @(posedge CLK) disable iff (SYS_RST)
        (acc && !PWRITE && kind == RGNP_BASER) |=> (PRDATA[2:0] == $past(sel_r));
    endproperty
    a_region_reads_sel: assert property (p_region_reads_sel) else $error("region field wrong");

    property p_valid_one_retargets;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_BASER && PSTRB[0] && PWDATA[`RGNP_VALID_BIT])
        |=> (sel_r == $past(PWDATA[2:0]));
    endproperty
    a_valid_one_retargets: assert property (p_valid_one_retargets) else $error("no retarget");

    property p_valid_zero_keeps;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_BASER && !PWDATA[`RGNP_VALID_BIT]) |=> $stable(sel_r);
    endproperty
    a_valid_zero_keeps: assert property (p_valid_zero_keeps) else $error("selection moved");

    property p_full_base_zero;
        @(posedge CLK) disable iff (SYS_RST)
        (attr_mem_r[VIEW_SEL][5:1] == `RGNP_SIZE_FULL) |=> (VIEW_BASE == 32'h00000000);
    endproperty
    a_full_base_zero: assert property (p_full_base_zero) else $error("full region base nonzero");

    property p_fetch_dis;
        @(posedge CLK) disable iff (SYS_RST)
        ##1 (VIEW_FETCH_DIS == $past(attr_mem_r[VIEW_SEL][28]));
    endproperty
    a_fetch_dis: assert property (p_fetch_dis) else $error("fetch disable mismatch");

    property p_half_write_keeps_upper;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_ATTRR && PSTRB == 4'h3)
        |=> (attr_mem_r[$past(sel_r)][31:16] == $past(attr_mem_r[sel_r][31:16]));
    endproperty
    a_half_write_keeps_upper: assert property (p_half_write_keeps_upper) else $error("upper lost");

    property p_ready_one_cycle;
        @(posedge CLK) disable iff (SYS_RST)
        PREADY |=> !PREADY;
    endproperty
    a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("pready held");

    property p_sel_write;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_SELR && PSTRB[0]) |=> (sel_r == $past(PWDATA[2:0]));
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selection not loaded");

    property p_sel_reads;
        @(posedge CLK) disable iff (SYS_RST)
        (acc && !PWRITE && kind == RGNP_SELR) |=> (PRDATA == {29'h0, $past(sel_r)});
    endproperty
    a_sel_reads: assert property (p_sel_reads) else $error("selection read wrong");

    property p_attr_store;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_ATTRR && PSTRB == 4'hF)
        |=> (attr_mem_r[$past(sel_r)] == ($past(PWDATA) & `RGNP_ATTR_MASK));
    endproperty
    a_attr_store: assert property (p_attr_store) else $error("attr word not stored");

    property p_half_write_keeps_lower;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_ATTRR && PSTRB == 4'hC)
        |=> (attr_mem_r[$past(sel_r)][15:0] == $past(attr_mem_r[sel_r][15:0]));
    endproperty
    a_half_write_keeps_lower: assert property (p_half_write_keeps_lower) else $error("lower lost");

    property p_fd_write;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_ATTRR && PSTRB[3])
        |=> (attr_mem_r[$past(sel_r)][28] == $past(PWDATA[28]));
    endproperty
    a_fd_write: assert property (p_fd_write) else $error("fetch disable not stored");

    property p_srd_write;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_ATTRR && PSTRB[1])
        |=> (attr_mem_r[$past(sel_r)][15:8] == $past(PWDATA[15:8]));
    endproperty
    a_srd_write: assert property (p_srd_write) else $error("subregion bits not stored");

    property p_base_valid_zero;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_BASER && PSTRB == 4'hF && !PWDATA[`RGNP_VALID_BIT])
        |=> (base_mem_r[$past(sel_r)] == ($past(PWDATA) & `RGNP_BASE_MASK));
    endproperty
    a_base_valid_zero: assert property (p_base_valid_zero) else $error("base not stored");

    property p_base_valid_one;
        @(posedge CLK) disable iff (SYS_RST)
        (wr && kind == RGNP_BASER && PSTRB == 4'hF && PWDATA[`RGNP_VALID_BIT])
        |=> (base_mem_r[$past(PWDATA[2:0])] == ($past(PWDATA) & `RGNP_BASE_MASK));
    endproperty
    a_base_valid_one: assert property (p_base_valid_one) else $error("retarget base lost");

    property p_srd_view;
        @(posedge CLK) disable iff (SYS_RST)
        ##1 (VIEW_SRD == $past(attr_mem_r[VIEW_SEL][15:8]));
    endproperty
    a_srd_view: assert property (p_srd_view) else $error("subregion view mismatch");

    property p_enable_view;
        @(posedge CLK) disable iff (SYS_RST)
        ##1 (VIEW_ENABLE == $past(attr_mem_r[VIEW_SEL][0]));
    endproperty
    a_enable_view: assert property (p_enable_view) else $error("enable view mismatch");

    property p_attr_view;
        @(posedge CLK) disable iff (SYS_RST)
        ##1 (VIEW_ATTR == $past(attr_mem_r[VIEW_SEL]));
    endproperty
    a_attr_view: assert property (p_attr_view) else $error("attr view mismatch");

    property p_base_aligned;
        @(posedge CLK) disable iff (SYS_RST)
        (attr_mem_r[VIEW_SEL][5:1] != `RGNP_SIZE_FULL)
        |=> ((VIEW_BASE & ~(32'hFFFFFFFF << ($past(attr_mem_r[VIEW_SEL][5:1]) + 6'h01)))
             == 32'h00000000);
    endproperty
    a_base_aligned: assert property (p_base_aligned) else $error("base below N");

    property p_alias_attr_read;
        @(posedge CLK) disable iff (SYS_RST)
        (acc && !PWRITE && (PADDR == `RGNP_OFS_ATTR_A1 || PADDR == `RGNP_OFS_ATTR_A2))
        |=> (PRDATA == $past(attr_mem_r[sel_r]));
    endproperty
    a_alias_attr_read: assert property (p_alias_attr_read) else $error("attr alias read");

    property p_alias_base_read;
        @(posedge CLK) disable iff (SYS_RST)
        (acc && !PWRITE && (PADDR == `RGNP_OFS_BASE_A1 || PADDR == `RGNP_OFS_BASE_A2))
        |=> (PRDATA == ($past(base_mem_r[sel_r]) | {29'h0, $past(sel_r)}));
    endproperty
    a_alias_base_read: assert property (p_alias_base_read) else $error("base alias read");
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`include "rgnp_regs.svh"
module tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'h0;
    logic [2:0]  view_sel = 3'h0;
    logic [31:0] prdata, view_base, view_attr, d;
    logic        pready, pslverr, view_fd, view_en;
    logic [7:0]  view_srd;
    logic [31:0] m_base[8], m_attr[8];
    logic [2:0]  m_sel;
    logic [3:0]  s;
    logic [4:0]  sz;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          k;
    logic [11:0] offs[8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018,
                             12'h01C};
    logic [3:0]  lanes[3] = '{4'hF, 4'hC, 4'h3};

    rgnp_top rgnp_top_inst (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .VIEW_SEL(view_sel), .VIEW_BASE(view_base),
        .VIEW_ATTR(view_attr), .VIEW_FETCH_DIS(view_fd), .VIEW_SRD(view_srd),
        .VIEW_ENABLE(view_en));

    initial forever #5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, then the model follows what a write should do
    task automatic xfer(input int k, input logic w, input logic [31:0] d, input logic [3:0] s);
        int          n;
        logic [31:0] exp;
        exp = (k == 0) ? {29'h0, m_sel} : (k == 7) ? 32'h0 :
              k[0] ? (m_base[m_sel] | {29'h0, m_sel}) : m_attr[m_sel];
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= offs[k];
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            $display("unexpected at %0t: no pready", $time);
        end
        chk({31'h0, pslverr}, {31'h0, k == 7});
        if (!w)
            chk(prdata, exp);
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && k == 0 && s[0])
            m_sel = d[2:0];
        if (w && k[0] && k != 7 && s == 4'hF) begin
            if (d[4])
                m_sel = d[2:0];
            m_base[m_sel] = d & 32'hFFFFFFE0;
        end
        if (w && k inside {2, 4, 6})
            for (int i = 0; i < 4; i++)
                if (s[i])
                    m_attr[m_sel][8*i+:8] = d[8*i+:8] & `RGNP_ATTR_MASK >> (8 * i);
    endtask

    task automatic view(input logic [2:0] r);
        logic [4:0] z;
        @(posedge clk);
        view_sel <= r;
        repeat (3) @(posedge clk);
        @(negedge clk);
        z = m_attr[r][5:1];
        chk(view_base, z == 5'h1F ? 32'h0 : m_base[r] & (32'hFFFFFFFF << (z + 1)));
        chk(view_attr, m_attr[r]);
        chk({view_fd, view_srd, view_en}, {m_attr[r][28], m_attr[r][15:8], m_attr[r][0]});
    endtask

    task results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end

    initial begin
        void'($urandom(32'hB392CC05));
        m_base = '{default: 32'h0};
        m_attr = '{default: 32'h0};
        m_sel = 3'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 8; k++)
            xfer(k, 1'b0, 32'h0, 4'hF);
        view(3'h0);
        for (int i = 0; i < 60; i++) begin
            k = $urandom % 8;
            d = $urandom;
            s = 4'hF;
            if (k inside {2, 4, 6}) begin
                d[5:1] = 5'(4 + $urandom % 28);
                if (d[5:1] <= 5'h06)
                    d[15:8] = 8'h00;
                s = lanes[$urandom % 3];
            end
            sz = m_attr[d[4] ? d[2:0] : m_sel][5:1];
            if (k[0] && k != 7 && sz != 5'h1F)
                d[31:5] = d[31:5] & (27'h7FFFFFF << sz[4:0] - 4);
            xfer(k, 1'b1, d, s);
            xfer(k, 1'b0, 32'h0, 4'hF);
            view(m_sel);
            view(3'($urandom % 8));
        end
        xfer(0, 1'b1, 32'h00000005, 4'hF);
        xfer(2, 1'b1, 32'h1000003F, 4'hF);
        xfer(5, 1'b1, 32'h12345660, 4'hF);
        view(3'h5);
        results();
    end
endmodule
